// ===== rtl/ivpc_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types of the interrupt vector and priority control
// ----------------------------------------------------------------------------
package ivpc_pkg;

  // Source counts and widths
  localparam int NSRC = 45;          // Maskable sources, default priority 0..44
  localparam int FLAG_W = 48;        // Three 16-bit flag words
  localparam int WORD_W = 16;        // Register data width
  localparam int NWORD = 3;          // Words per flag group
  localparam int ADDR_W = 5;         // Register address width
  localparam int VEC_W = 20;         // Vector address width
  localparam int NPIN = 12;          // External interrupt pins
  localparam int SRC_W = 6;          // Width of a source index

  // Register addresses (word index)
  localparam logic [4:0] A_IF0 = 5'h00;   // Request flags, words 0..2
  localparam logic [4:0] A_MK0 = 5'h03;   // Mask flags, words 0..2
  localparam logic [4:0] A_PRL0 = 5'h06;  // Priority low bits, words 0..2
  localparam logic [4:0] A_PRH0 = 5'h09;  // Priority high bits, words 0..2
  localparam logic [4:0] A_EGP = 5'h0c;   // Rising enables, pins 0..11
  localparam logic [4:0] A_EGN = 5'h0d;   // Falling enables, pins 0..11
  localparam logic [4:0] A_PSW = 5'h0e;   // Program status word
  localparam logic [4:0] A_LOW_VOLTAGE_CONTROL_REG = 5'h0f;  // Low-voltage control register
  localparam logic [4:0] A_EVST = 5'h10;  // Event status, write one to clear
  localparam logic [4:0] A_EVMK = 5'h11;  // Event mask

  // Special source positions
  localparam logic [5:0] SRC_LVI = 6'h01;     // Low-voltage maskable request
  localparam logic [5:0] SRC_SER0 = 6'h0d;    // Shared serial 0 flag
  localparam logic [5:0] SRC_TM10 = 6'h28;    // Timer channel 10
  localparam logic [5:0] SRC_MULDIV = 6'h2c;  // Multiply/divide done
  localparam int PIN_SPLIT = 6;               // Pins below go low block
  localparam int PIN_LO_SRC = 2;              // Source of pin 0
  localparam int PIN_HI_SRC = 34;             // Source of pin 6

  // Vector table
  localparam logic [19:0] VEC_RESET = 20'h00000;
  localparam logic [19:0] VEC_BRK = 20'h0007e;
  localparam logic [19:0] VEC_TM10 = 20'h00056;
  localparam logic [19:0] VEC_MULDIV = 20'h0005e;
  localparam logic [5:0] VEC_GAP_SRC = 6'h1b;     // First source past hole
  localparam logic [19:0] VEC_OFS_LO = 20'h00004;
  localparam logic [19:0] VEC_OFS_HI = 20'h00006;

  // Fields and reset values
  localparam logic [7:0] OPC_ILLEGAL = 8'hff;
  localparam int PSW_IE = 7;
  localparam int PSW_IN_SERVICE_LEVEL_BIT1 = 2;
  localparam int PSW_IN_SERVICE_LEVEL_BIT0 = 1;
  localparam logic [7:0] PSW_RESET = 8'h06;
  localparam int LOW_VOLTAGE_CONTROL_REG_SEL = 1;
  localparam logic [47:0] FLAG_VALID = 48'h1fffffffffff;
  localparam logic [47:0] MK_RESET = 48'hffffffffffff;
  localparam logic [47:0] PR_RESET = 48'hffffffffffff;
  localparam logic [1:0] LVL_LOWEST = 2'h3;
  localparam int EV_ACK = 0;     // Maskable request acknowledged
  localparam int EV_BRK = 1;     // Software break taken
  localparam int EV_OVR = 2;     // Request arrived on a set flag
  localparam int EV_W = 3;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } ivpc_bus_req_t;

  // Reset causes
  typedef struct packed {
    logic powerOnClear;
    logic lowVoltageDetect;
    logic watchdogOverflow;
  } ivpc_rst_src_t;

endpackage : ivpc_pkg

// ===== rtl/ivpc_edge_sync.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Pin synchroniser and edge detector
// ----------------------------------------------------------------------------
module ivpc_edge_sync #(
  parameter int W = 12
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] pinIn,
  input wire logic [W-1:0] riseEn,
  input wire logic [W-1:0] fallEn,
  output logic [W-1:0] edgePulse
);

  logic [W-1:0] meta_ff;   // First stage, read only by the second
  logic [W-1:0] sync_ff;   // Second stage
  logic [W-1:0] last_ff;   // Previous synchronised level
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;
  logic [W-1:0] nxt_last;

  // Next values: shift the pin through three stages
  always_comb begin
    nxt_meta = pinIn;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  // Register stages
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  // Both edges may be enabled at once
  assign edgePulse = (sync_ff & ~last_ff & riseEn)
                   | (~sync_ff & last_ff & fallEn);

endmodule : ivpc_edge_sync
`default_nettype wire

// ===== rtl/ivpc_top.sv
// Contract
// - Simultaneous requests served by default priority 0..44
// - Timer channels 10-13 request 40-43, vectors 56H-5CH
// - Multiply/divide done: priority 44, vector 5EH
// - Software break is unmaskable, vector 7EH
// - Every reset cause uses vector 00000H
// - Low voltage resets only when select bit set
// - Opcode FFH executed causes reset
// - No illegal-opcode reset under debug emulation
// - Six register groups control interrupts
// - Per source request, mask, two priority bits
// - Serial 0 transmit and sync share flag 13
// - Pins 0-11 are edge-detected maskable requests
// - Rising edges enabled by own registers
// - Falling edges enabled by own registers
// - Acknowledge clears that source's request flag
// - Reset clears all request flags
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ivpc_top (
  input wire logic clock,
  input wire logic resetn,
  input wire ivpc_pkg::ivpc_bus_req_t busReq,
  output logic [15:0] rdata,
  input wire logic [44:0] intReq,
  input wire logic timerCh10Irq,
  input wire logic timerCh11Irq,
  input wire logic timerCh12Irq,
  input wire logic timerCh13Irq,
  input wire logic muldivDoneIrq,
  input wire logic serial0TxDoneIrq,
  input wire logic serial0SyncDoneIrq,
  input wire logic [11:0] extPinIrq,
  input wire logic softwareBreakInstr,
  input wire logic instrValid,
  input wire logic [7:0] instrOpcode,
  input wire logic debugEmulation,
  input wire logic resetPinN,
  input wire ivpc_pkg::ivpc_rst_src_t rstSrc,
  input wire logic coreAck,
  output logic intRequest,
  output logic [19:0] intVector,
  output logic [1:0] intLevel,
  output logic resetRequest,
  output logic irq
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // Word select of a three-word register group
  function automatic logic isWord(input logic [4:0] a, input logic [4:0] base,
                                  input int w);
    return a == (base + 5'(w));
  endfunction : isWord

  // Vector of a maskable source; one hole in the table past source 26
  function automatic logic [19:0] srcVector(input logic [5:0] s);
    logic [19:0] v;
    v = {13'h0000, s, 1'b0};
    return v + ((s < ivpc_pkg::VEC_GAP_SRC) ? ivpc_pkg::VEC_OFS_LO
                                            : ivpc_pkg::VEC_OFS_HI);
  endfunction : srcVector

  // Source number of an external pin
  function automatic logic [5:0] pinSrc(input int n);
    return (n < ivpc_pkg::PIN_SPLIT) ? 6'(ivpc_pkg::PIN_LO_SRC + n)
                          : 6'(ivpc_pkg::PIN_HI_SRC + n - ivpc_pkg::PIN_SPLIT);
  endfunction : pinSrc

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [47:0] ifFlags_ff, nxt_ifFlags;   // Request flags
  logic [47:0] mask_ff, nxt_mask;         // Mask flags
  logic [47:0] prLow_ff, nxt_prLow;       // Priority low bits
  logic [47:0] prHigh_ff, nxt_prHigh;     // Priority high bits
  logic [15:0] riseEn_ff, nxt_riseEn;     // Rising enables
  logic [15:0] fallEn_ff, nxt_fallEn;     // Falling enables
  logic [7:0] psw_ff, nxt_psw;            // Status word
  logic [7:0] lvCtrl_ff, nxt_lvCtrl;      // Low-voltage control
  logic [2:0] evStat_ff, nxt_evStat;      // Sticky events
  logic [2:0] evMask_ff, nxt_evMask;      // Event enables
  logic brkPend_ff, nxt_brkPend;          // Software break waiting
  logic selValid_ff, nxt_selValid;        // Maskable request offered
  logic [5:0] selSrc_ff, nxt_selSrc;      // Offered source
  logic [1:0] level_ff, nxt_level;        // Offered level
  logic [19:0] vector_ff, nxt_vector;     // Offered vector
  logic resetReq_ff, nxt_resetReq;        // Reset request
  logic [15:0] rdata_ff, nxt_rdata;       // Read data
  logic rstMeta_ff, rstSync_ff;           // Reset pin synchroniser

  logic [47:0] hwSet;                     // Hardware request pulses
  logic [11:0] pinEdge;                   // Detected pin edges
  logic ackMaskable;                      // Core takes a maskable request
  logic ackBrk;                           // Core takes the break
  logic otherCause;                       // Reset causes but opcode
  logic illegalOp;                        // Opcode FFH seen
  logic [1:0] ispNext;                    // Level allowed after this edge
  logic [1:0] lvl;                        // Loop scratch
  logic found;                            // Loop scratch

  // --------------------------------------------------------------------------
  // Pin edge detection
  // --------------------------------------------------------------------------
  ivpc_edge_sync #(.W(ivpc_pkg::NPIN)) u_pins (
    .clock(clock),
    .resetn(resetn),
    .pinIn(extPinIrq),
    .riseEn(riseEn_ff[11:0]),
    .fallEn(fallEn_ff[11:0]),
    .edgePulse(pinEdge)
  );

  // --------------------------------------------------------------------------
  // Request sources
  // --------------------------------------------------------------------------
  // Gather pulses into source positions
  always_comb begin
    hwSet = '0;
    hwSet[ivpc_pkg::NSRC-1:0] = intReq;
    for (int n = 0; n < ivpc_pkg::NPIN; n++) begin
      hwSet[pinSrc(n)] = pinEdge[n];
    end
    hwSet[ivpc_pkg::SRC_SER0] = serial0TxDoneIrq
                              | serial0SyncDoneIrq;
    hwSet[ivpc_pkg::SRC_TM10] = timerCh10Irq;
    hwSet[ivpc_pkg::SRC_TM10 + 6'h01] = timerCh11Irq;
    hwSet[ivpc_pkg::SRC_TM10 + 6'h02] = timerCh12Irq;
    hwSet[ivpc_pkg::SRC_TM10 + 6'h03] = timerCh13Irq;
    hwSet[ivpc_pkg::SRC_MULDIV] = muldivDoneIrq;
    // Low voltage is a maskable request unless it resets
    hwSet[ivpc_pkg::SRC_LVI] = rstSrc.lowVoltageDetect
                             & ~lvCtrl_ff[ivpc_pkg::LOW_VOLTAGE_CONTROL_REG_SEL];
  end

  // --------------------------------------------------------------------------
  // Reset causes
  // --------------------------------------------------------------------------
  // Opcode check is blocked under emulation
  always_comb begin
    illegalOp = instrValid && (instrOpcode == ivpc_pkg::OPC_ILLEGAL)
                && !debugEmulation;
    otherCause = !rstSync_ff | rstSrc.powerOnClear | rstSrc.watchdogOverflow
               | (rstSrc.lowVoltageDetect
                  & lvCtrl_ff[ivpc_pkg::LOW_VOLTAGE_CONTROL_REG_SEL]);
    nxt_resetReq = otherCause | illegalOp;
  end

  // --------------------------------------------------------------------------
  // Register and flag updates
  // --------------------------------------------------------------------------
  assign ackMaskable = coreAck && intRequest && selValid_ff && !brkPend_ff;
  assign ackBrk = coreAck && intRequest && brkPend_ff;

  // Software writes, then acknowledge, then hardware sets win
  always_comb begin
    nxt_ifFlags = ifFlags_ff;
    nxt_mask = mask_ff;
    nxt_prLow = prLow_ff;
    nxt_prHigh = prHigh_ff;
    nxt_riseEn = riseEn_ff;
    nxt_fallEn = fallEn_ff;
    nxt_psw = psw_ff;
    nxt_lvCtrl = lvCtrl_ff;
    nxt_evMask = evMask_ff;
    nxt_evStat = evStat_ff;
    nxt_brkPend = brkPend_ff;
    // Four three-word register groups
    for (int w = 0; w < ivpc_pkg::NWORD; w++) begin
      if (busReq.wr && isWord(busReq.addr, ivpc_pkg::A_IF0, w)) begin
        nxt_ifFlags[w*16 +: 16] = busReq.wdata;
      end
      if (busReq.wr && isWord(busReq.addr, ivpc_pkg::A_MK0, w)) begin
        nxt_mask[w*16 +: 16] = busReq.wdata;
      end
      if (busReq.wr && isWord(busReq.addr, ivpc_pkg::A_PRL0, w)) begin
        nxt_prLow[w*16 +: 16] = busReq.wdata;
      end
      if (busReq.wr && isWord(busReq.addr, ivpc_pkg::A_PRH0, w)) begin
        nxt_prHigh[w*16 +: 16] = busReq.wdata;
      end
    end
    if (busReq.wr) begin
      unique case (busReq.addr)
        ivpc_pkg::A_EGP: nxt_riseEn = busReq.wdata;
        ivpc_pkg::A_EGN: nxt_fallEn = busReq.wdata;
        ivpc_pkg::A_PSW: nxt_psw = busReq.wdata[7:0];
        ivpc_pkg::A_LOW_VOLTAGE_CONTROL_REG: nxt_lvCtrl = busReq.wdata[7:0];
        ivpc_pkg::A_EVMK: nxt_evMask = busReq.wdata[2:0];
        ivpc_pkg::A_EVST: nxt_evStat = evStat_ff & ~busReq.wdata[2:0];
        default: ;
      endcase
    end
    // Acknowledge: clear flag, raise in-service level, block nesting
    if (ackMaskable) begin
      nxt_ifFlags[selSrc_ff] = 1'b0;
      nxt_psw[ivpc_pkg::PSW_IE] = 1'b0;
      nxt_psw[ivpc_pkg::PSW_IN_SERVICE_LEVEL_BIT1] = level_ff[1];
      nxt_psw[ivpc_pkg::PSW_IN_SERVICE_LEVEL_BIT0] = level_ff[0];
    end
    if (ackBrk) begin
      nxt_brkPend = 1'b0;
      nxt_psw[ivpc_pkg::PSW_IE] = 1'b0;
    end
    // Hardware sets override any clear in the same cycle
    nxt_ifFlags = (nxt_ifFlags | hwSet) & ivpc_pkg::FLAG_VALID;
    nxt_brkPend = nxt_brkPend | softwareBreakInstr;
    nxt_evStat[ivpc_pkg::EV_ACK] = nxt_evStat[ivpc_pkg::EV_ACK] | ackMaskable;
    nxt_evStat[ivpc_pkg::EV_BRK] = nxt_evStat[ivpc_pkg::EV_BRK] | ackBrk;
    nxt_evStat[ivpc_pkg::EV_OVR] = nxt_evStat[ivpc_pkg::EV_OVR]
                                 | (|(hwSet & ifFlags_ff));
  end

  // --------------------------------------------------------------------------
  // Arbitration on the values of the coming cycle
  // --------------------------------------------------------------------------
  // Scan from 44 down so the lower number wins a tie
  always_comb begin
    ispNext = {nxt_psw[ivpc_pkg::PSW_IN_SERVICE_LEVEL_BIT1], nxt_psw[ivpc_pkg::PSW_IN_SERVICE_LEVEL_BIT0]};
    found = 1'b0;
    lvl = ivpc_pkg::LVL_LOWEST;
    nxt_selSrc = '0;
    nxt_level = ivpc_pkg::LVL_LOWEST;
    for (int i = ivpc_pkg::NSRC - 1; i >= 0; i--) begin
      lvl = {nxt_prHigh[i], nxt_prLow[i]};
      if (nxt_ifFlags[i] && !nxt_mask[i] && (lvl <= ispNext)
          && (!found || (lvl <= nxt_level))) begin
        found = 1'b1;
        nxt_selSrc = 6'(i);
        nxt_level = lvl;
      end
    end
    nxt_selValid = found && nxt_psw[ivpc_pkg::PSW_IE];
    // Reset, then break, then the maskable winner
    if (nxt_resetReq) begin
      nxt_vector = ivpc_pkg::VEC_RESET;
    end else if (nxt_brkPend) begin
      nxt_vector = ivpc_pkg::VEC_BRK;
    end else begin
      nxt_vector = srcVector(nxt_selSrc);
    end
  end

  // --------------------------------------------------------------------------
  // Read data, one cycle after the strobe
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    if (busReq.rd) begin
      for (int w = 0; w < ivpc_pkg::NWORD; w++) begin
        if (isWord(busReq.addr, ivpc_pkg::A_IF0, w)) begin
          nxt_rdata = ifFlags_ff[w*16 +: 16];
        end
        if (isWord(busReq.addr, ivpc_pkg::A_MK0, w)) begin
          nxt_rdata = mask_ff[w*16 +: 16];
        end
        if (isWord(busReq.addr, ivpc_pkg::A_PRL0, w)) begin
          nxt_rdata = prLow_ff[w*16 +: 16];
        end
        if (isWord(busReq.addr, ivpc_pkg::A_PRH0, w)) begin
          nxt_rdata = prHigh_ff[w*16 +: 16];
        end
      end
      unique case (busReq.addr)
        ivpc_pkg::A_EGP: nxt_rdata = riseEn_ff;
        ivpc_pkg::A_EGN: nxt_rdata = fallEn_ff;
        ivpc_pkg::A_PSW: nxt_rdata = {8'h00, psw_ff};
        ivpc_pkg::A_LOW_VOLTAGE_CONTROL_REG: nxt_rdata = {8'h00, lvCtrl_ff};
        ivpc_pkg::A_EVST: nxt_rdata = {13'h0000, evStat_ff};
        ivpc_pkg::A_EVMK: nxt_rdata = {13'h0000, evMask_ff};
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Reset on resetn returns the block to its idle state; reset causes only raise resetRequest
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ifFlags_ff <= '0;
      mask_ff <= ivpc_pkg::MK_RESET;
      prLow_ff <= ivpc_pkg::PR_RESET;
      prHigh_ff <= ivpc_pkg::PR_RESET;
      riseEn_ff <= '0;
      fallEn_ff <= '0;
      psw_ff <= ivpc_pkg::PSW_RESET;
      lvCtrl_ff <= '0;
      evStat_ff <= '0;
      evMask_ff <= '0;
      brkPend_ff <= 1'b0;
      selValid_ff <= 1'b0;
      selSrc_ff <= '0;
      level_ff <= ivpc_pkg::LVL_LOWEST;
      vector_ff <= ivpc_pkg::VEC_RESET;
      resetReq_ff <= 1'b0;
      rdata_ff <= '0;
      rstMeta_ff <= 1'b1;
      rstSync_ff <= 1'b1;
    end else begin
      ifFlags_ff <= nxt_ifFlags;
      mask_ff <= nxt_mask;
      prLow_ff <= nxt_prLow;
      prHigh_ff <= nxt_prHigh;
      riseEn_ff <= nxt_riseEn;
      fallEn_ff <= nxt_fallEn;
      psw_ff <= nxt_psw;
      lvCtrl_ff <= nxt_lvCtrl;
      evStat_ff <= nxt_evStat;
      evMask_ff <= nxt_evMask;
      brkPend_ff <= nxt_brkPend;
      selValid_ff <= nxt_selValid;
      selSrc_ff <= nxt_selSrc;
      level_ff <= nxt_level;
      vector_ff <= nxt_vector;
      resetReq_ff <= nxt_resetReq;
      rdata_ff <= nxt_rdata;
      rstMeta_ff <= resetPinN;
      rstSync_ff <= rstMeta_ff;
    end
  end

  // Outputs
  assign intRequest = (selValid_ff | brkPend_ff) & ~resetReq_ff;
  assign intVector = vector_ff;
  assign intLevel = level_ff;
  assign resetRequest = resetReq_ff;
  assign rdata = rdata_ff;
  assign irq = |(evStat_ff & evMask_ff);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_tm10;
    timerCh10Irq |=> ifFlags_ff[ivpc_pkg::SRC_TM10];
  endproperty
  a_tm10: assert property (p_tm10) else $error("timer 10 flag lost");

  property p_tm10vec;
    intRequest && !brkPend_ff && selSrc_ff == ivpc_pkg::SRC_TM10
      |-> intVector == ivpc_pkg::VEC_TM10;
  endproperty
  a_tm10vec: assert property (p_tm10vec) else $error("timer 10 vector");

  property p_muldiv;
    muldivDoneIrq ##1 (!brkPend_ff && !resetReq_ff && selValid_ff
      && selSrc_ff == ivpc_pkg::SRC_MULDIV)
      |-> ifFlags_ff[ivpc_pkg::SRC_MULDIV]
          && intVector == ivpc_pkg::VEC_MULDIV;
  endproperty
  a_muldiv: assert property (p_muldiv) else $error("muldiv request");

  property p_brk;
    (softwareBreakInstr ##1 !resetRequest)
      |-> intRequest && intVector == ivpc_pkg::VEC_BRK;
  endproperty
  a_brk: assert property (p_brk) else $error("break not offered");

  property p_rstvec;
    resetRequest |-> intVector == ivpc_pkg::VEC_RESET && !intRequest;
  endproperty
  a_rstvec: assert property (p_rstvec) else $error("reset vector");

  property p_lvd;
    rstSrc.lowVoltageDetect && lvCtrl_ff[ivpc_pkg::LOW_VOLTAGE_CONTROL_REG_SEL] |=> resetRequest;
  endproperty
  a_lvd: assert property (p_lvd) else $error("low voltage reset");

  property p_illegal;
    instrValid && instrOpcode == ivpc_pkg::OPC_ILLEGAL && !debugEmulation
      |=> resetRequest;
  endproperty
  a_illegal: assert property (p_illegal) else $error("opcode reset");

  property p_debug;
    instrValid && debugEmulation && !otherCause |=> !resetRequest;
  endproperty
  a_debug: assert property (p_debug) else $error("debug reset");

  property p_ser0;
    serial0SyncDoneIrq || serial0TxDoneIrq |=> ifFlags_ff[ivpc_pkg::SRC_SER0];
  endproperty
  a_ser0: assert property (p_ser0) else $error("serial 0 flag");

  property p_ackclr;
    ackMaskable && !hwSet[selSrc_ff] && !busReq.wr
      |=> !ifFlags_ff[$past(selSrc_ff)];
  endproperty
  a_ackclr: assert property (p_ackclr) else $error("flag not cleared");

  property p_accept;
    intRequest && !brkPend_ff |-> psw_ff[ivpc_pkg::PSW_IE]
      && ifFlags_ff[selSrc_ff] && !mask_ff[selSrc_ff]
      && level_ff <= {psw_ff[ivpc_pkg::PSW_IN_SERVICE_LEVEL_BIT1], psw_ff[ivpc_pkg::PSW_IN_SERVICE_LEVEL_BIT0]};
  endproperty
  a_accept: assert property (p_accept) else $error("bad acceptance");

  c_ack: cover property (ackMaskable);
  c_brk: cover property (ackBrk);
  c_rst: cover property (resetRequest);
  c_irq: cover property (irq);

endmodule : ivpc_top
`default_nettype wire

// ===== testbench/ivpc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Core model: takes each offered request after a chosen delay
// ----------------------------------------------------------------------
module ivpc_core_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic intRequest,
  input wire logic [1:0] ackDelay,
  output logic coreAck
);
  logic [1:0] waitCnt_ff; // Cycles the offer has stood
  // One pulse per offer, dropped at once so no offer is taken twice
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      coreAck <= 1'b0;
      waitCnt_ff <= 2'h0;
    end else if (coreAck || !intRequest) begin
      coreAck <= 1'b0;
      waitCnt_ff <= 2'h0;
    end else if (waitCnt_ff == ackDelay) begin
      coreAck <= 1'b1;
    end else begin
      waitCnt_ff <= waitCnt_ff + 2'h1;
    end
  end
endmodule : ivpc_core_model
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  ivpc_pkg::ivpc_bus_req_t busReq = '0;
  ivpc_pkg::ivpc_rst_src_t rstSrc = '0;
  logic [4:0] tmr = '0; // Timers 10..13, multiply/divide
  logic [1:0] ser = '0; // Serial 0 transmit, sync
  logic [11:0] pins = '0;
  logic software_break_instr = 1'b0, iValid = 1'b0, dbg = 1'b0, rdPend = 1'b0;
  logic [1:0] ackDelay = 2'h0;
  logic [7:0] opc = 8'hff; // Executed opcode
  logic rstPin = 1'b1; // Reset pin, active low
  logic [44:0] ireq = '0; // Generic request pulses
  logic [1:0] lvl; // Offered level
  logic ack, intRequest, resetRequest, irq;
  logic [15:0] rdata;
  logic [19:0] intVector;
  logic [19:0] vq[$]; // Expected vectors, oldest first
  logic [15:0] rq[$]; // Expected read data
  int fail_count = 0, n_checks = 0, nAck = 0, j, k;
  always #25 clock = ~clock;
  ivpc_top u_dut (.clock(clock), .resetn(resetn), .busReq(busReq),
    .rdata(rdata), .intReq(ireq), .timerCh10Irq(tmr[0]),
    .timerCh11Irq(tmr[1]), .timerCh12Irq(tmr[2]), .timerCh13Irq(tmr[3]),
    .muldivDoneIrq(tmr[4]), .serial0TxDoneIrq(ser[0]),
    .serial0SyncDoneIrq(ser[1]), .extPinIrq(pins),
    .softwareBreakInstr(software_break_instr), .instrValid(iValid), .instrOpcode(opc),
    .debugEmulation(dbg), .resetPinN(rstPin), .rstSrc(rstSrc),
    .coreAck(ack), .intRequest(intRequest), .intVector(intVector),
    .intLevel(lvl), .resetRequest(resetRequest), .irq(irq));
  ivpc_core_model u_core (.clock(clock), .resetn(resetn),
    .intRequest(intRequest), .ackDelay(ackDelay), .coreAck(ack));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    busReq <= {1'b1, 1'b0, a, d};
    @(posedge clock);
    busReq <= '0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    rq.push_back(e);
    busReq <= {1'b0, 1'b1, a, 16'h0};
    @(posedge clock);
    busReq <= '0;
    @(posedge clock);
  endtask : rd
  // Bounded wait for the core to take one more request
  task automatic wack(input int n0);
    for (int t = 0; t < 30 && nAck == n0; t++) @(posedge clock);
    if (nAck == n0) begin
      fail_count++;
      summarize();
    end
  endtask : wack
  // Re-enable with all levels allowed, then wait for each ack
  task automatic serve(input int n);
    repeat (n) begin
      k = nAck;
      wr(ivpc_pkg::A_PSW, 16'h0086);
      wack(k);
    end
  endtask : serve
  task automatic cause(input logic [2:0] c, input logic e);
    rstSrc <= {1'b0, c[1], c[0]};
    iValid <= c[2];
    @(posedge clock);
    rstSrc <= '0;
    iValid <= 1'b0;
    #1 chk({19'h0, resetRequest}, {19'h0, e});
    chk(e ? intVector : 20'h0, 20'h0);
    repeat (3) @(posedge clock);
  endtask : cause
  // Monitor: compares read data and taken vectors against the notes
  always @(posedge clock) begin
    if (rdPend) chk({4'h0, rdata}, {4'h0, rq.pop_front()});
    rdPend <= busReq.rd;
    if (ack && intRequest) begin
      chk(intVector, vq.pop_front());
      nAck <= nAck + 1;
    end
  end
  initial begin
    j = $urandom(82094);
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(ivpc_pkg::A_PSW, 16'h0006);
    rd(ivpc_pkg::A_MK0, 16'hffff);
    rd(ivpc_pkg::A_IF0, 16'h0000);
    rd(5'h1f, 16'h0000);
    $display("reset values done");
    wr(ivpc_pkg::A_EGP, 16'h0001);
    pins <= 12'h001;
    ser <= 2'b01;
    @(posedge clock);
    ser <= 2'b00;
    repeat (4) @(posedge clock);
    rd(ivpc_pkg::A_IF0, 16'h2004);
    wr(ivpc_pkg::A_IF0, 16'h0000);
    wr(ivpc_pkg::A_EGP, 16'h0000);
    wr(ivpc_pkg::A_EGN, 16'h0001);
    pins <= 12'h000;
    ser <= 2'b10;
    @(posedge clock);
    ser <= 2'b00;
    repeat (4) @(posedge clock);
    rd(ivpc_pkg::A_IF0, 16'h2004);
    wr(ivpc_pkg::A_IF0, 16'h0000);
    $display("pins and shared flag done");
    wr(ivpc_pkg::A_MK0 + 5'h2, 16'h0000);
    ackDelay <= 2'($urandom);
    for (j = 0; j < 5; j++) vq.push_back(20'h56 + 20'(2 * j));
    tmr <= 5'h1f;
    @(posedge clock);
    tmr <= 5'h00;
    serve(5);
    wr(ivpc_pkg::A_PRL0 + 5'h2, 16'hefff);
    wr(ivpc_pkg::A_PRH0 + 5'h2, 16'hefff);
    j = $urandom % 4;
    vq.push_back(20'h5e);
    vq.push_back(20'h56 + 20'(2 * j));
    tmr <= 5'h10 | (5'h01 << j);
    @(posedge clock);
    tmr <= 5'h00;
    #1 chk({18'h0, lvl}, 20'h0);
    serve(2);
    j = $urandom % 5;
    vq.push_back(20'h4);
    vq.push_back(20'h14 + 20'(2 * j));
    wr(ivpc_pkg::A_MK0, 16'h0000);
    ireq <= 45'h1 | (45'h100 << j);
    @(posedge clock);
    ireq <= '0;
    serve(2);
    $display("arbitration done");
    vq.push_back(20'h7e);
    k = nAck;
    software_break_instr <= 1'b1;
    @(posedge clock);
    software_break_instr <= 1'b0;
    wack(k);
    wr(ivpc_pkg::A_EVMK, 16'h0002);
    #1 chk({19'h0, irq}, 20'h1);
    @(posedge clock);
    wr(ivpc_pkg::A_EVST, 16'h0007);
    #1 chk({19'h0, irq}, 20'h0);
    @(posedge clock);
    $display("break done");
    cause(3'b001, 1'b1);
    cause(3'b010, 1'b0);
    wr(ivpc_pkg::A_LOW_VOLTAGE_CONTROL_REG, 16'h0002);
    cause(3'b010, 1'b1);
    dbg <= 1'b1;
    cause(3'b100, 1'b0);
    dbg <= 1'b0;
    cause(3'b100, 1'b1);
    opc <= 8'($urandom % 255);
    cause(3'b100, 1'b0);
    rstPin <= 1'b0;
    repeat (3) @(posedge clock);
    #1 chk({19'h0, resetRequest}, 20'h1);
    rstPin <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk({19'h0, resetRequest}, 20'h0);
    $display("reset causes done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
